// File: logic/mbx_buf2.sv
`timescale 1ns/1ps

// two-entry buffer; ready and valid come from flops so both sides see clean levels
module mbx_buf2 #(
    parameter int unsigned W = 36
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic [W-1:0] slot_reg [0:1];
    logic         rd_ptr_reg;
    logic         wr_ptr_reg;
    logic [1:0]   count_reg;
    logic [1:0]   count_next;
    logic         push;
    logic         pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = slot_reg[rd_ptr_reg];

    // occupancy after this edge
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // pointers and counters; flags are registered copies of the next count
    always_ff @(posedge clk) begin
        if (!nrst || flush) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            in_ready   <= 1'b0;
            out_valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_next;
            in_ready  <= (count_next != mbx_pkg::BUF_DEPTH);
            out_valid <= (count_next != 2'h0);
        end
    end

    // storage needs no reset; nothing reads a slot before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            slot_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule : mbx_buf2

// File: logic/mbx_pkg.sv
package mbx_pkg;

    // data path widths
    localparam int unsigned LONG_W  = 36;
    localparam int unsigned WORD_W  = 18;
    localparam int unsigned BYTE_W  = 9;
    localparam int unsigned IDX_W   = 2;

    // index of the last port b read that drains one long word, per bus size (reads minus one)
    localparam logic [IDX_W-1:0] LONG_PARTS_LAST = 2'h0;
    localparam logic [IDX_W-1:0] WORD_PARTS_LAST = 2'h1;
    localparam logic [IDX_W-1:0] BYTE_PARTS_LAST = 2'h3;

    // field positions inside a long word
    localparam int unsigned WORD_HI_LSB = 18;
    localparam int unsigned BYTE_SPAN   = 9;

    // reset values
    localparam logic [LONG_W-1:0] DATA_RST  = 36'h0_0000_0000;
    localparam logic [IDX_W-1:0]  IDX_RST   = 2'h0;
    localparam logic              FLAG_IDLE = 1'b1;
    localparam logic              OE_OFF_N  = 1'b1;

    // masks that keep only the lanes a bus size may carry
    localparam logic [LONG_W-1:0] MASK_LONG = 36'hF_FFFF_FFFF;
    localparam logic [LONG_W-1:0] MASK_WORD = 36'h0_0003_FFFF;
    localparam logic [LONG_W-1:0] MASK_BYTE = 36'h0_0000_01FF;

    // two-entry buffer depth in front of the serialiser
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // port b bus size, one-hot
    typedef enum logic [2:0] {
        MBX_SIZE_LONG = 3'h1,
        MBX_SIZE_WORD = 3'h2,
        MBX_SIZE_BYTE = 3'h4
    } mbx_size_t;

    // endian order of word and byte sequencing
    typedef enum logic [1:0] {
        MBX_ORDER_BIG    = 2'h1,
        MBX_ORDER_LITTLE = 2'h2
    } mbx_order_t;

endpackage : mbx_pkg

// File: logic/mbx_top.sv
`timescale 1ns/1ps

// Operation
// R1 - two 36-bit mailboxes, one each direction
// R2 - mailbox select picks mailbox or fifo
// R3 - port a mailbox write loads a-to-b mailbox
// R4 - a-to-b mailbox keeps only bus-size lanes
// R5 - port b mailbox write loads b-to-a mailbox
// R6 - b-to-a mailbox keeps only bus-size lanes
// R7 - accepted mailbox write drives full flag low
// R8 - writes ignored while full flag low
// R9 - read bus from mailbox or fifo register
// R10 - port b mailbox read sets a-to-b flag high
// R11 - port b mail read shows bus-size lanes
// R12 - port a mailbox read sets b-to-a flag high
// R13 - port a mail read shows bus-size lanes
// R14 - reading a mailbox leaves contents intact
// R15 - decode bus size from match and size inputs
// R16 - host holds size inputs static after reset
// R17 - size and order apply at reset completion
// R18 - big or little endian part order
// R19 - endian caught at master reset release
// R20 - memory moves whole words; mail unconverted
// R21 - long moves whole; narrower keeps remainder aside
// R22 - unused port b lanes may be anything
// R23 - both mailbox flags high after reset
// R24 - next word fetched only once drained
module mbx_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        master_reset_n,
    input  wire logic        width_match_select,
    input  wire logic        size_select,
    input  wire logic        endian_order_select,
    output logic             full_or_input_ready_flag,
    input  wire logic        port_a_chip_select_n,
    input  wire logic        port_a_write_read_n,
    input  wire logic        port_a_enable,
    input  wire logic        port_a_mailbox_select,
    input  wire logic [35:0] port_a_data_in,
    output logic [35:0]      port_a_data_out,
    output logic             port_a_data_oe_n,
    input  wire logic        port_b_chip_select_n,
    input  wire logic        port_b_write_n_read,
    input  wire logic        port_b_enable,
    input  wire logic        port_b_mailbox_select,
    input  wire logic [35:0] port_b_data_in,
    output logic [35:0]      port_b_data_out,
    output logic             port_b_data_oe_n,
    output logic             port_b_fifo_data_ready,
    output logic             a_to_b_mail_full_n,
    output logic             b_to_a_mail_full_n,
    input  wire logic        mem_word_valid,
    output logic             mem_word_ready,
    input  wire logic [35:0] mem_word
);

    // configuration and status
    mbx_pkg::mbx_size_t        bus_size_reg;
    mbx_pkg::mbx_order_t       order_reg;
    logic                      master_reset_n_reg;
    logic                      cfg_done_reg;

    // mailboxes and their active-low full flags
    logic [35:0]               a_to_b_mailbox_reg;
    logic [35:0]               b_to_a_mailbox_reg;
    logic                      a_to_b_mail_full_n_reg;
    logic                      b_to_a_mail_full_n_reg;

    // fifo read serialiser
    logic [35:0]               aux_word_reg;
    logic [35:0]               fifo_out_reg;
    logic [1:0]                part_idx_reg;
    logic [1:0]                part_last;
    logic [35:0]               size_mask;

    // decoded port accesses
    logic                      a_sel;
    logic                      a_mail_write;
    logic                      a_mail_read;
    logic                      a_reading;
    logic                      b_sel;
    logic                      b_mail_write;
    logic                      b_mail_read;
    logic                      b_fifo_read;
    logic                      b_reading;

    // buffer interface
    logic                      buf_valid;
    logic                      buf_ready;
    logic [35:0]               buf_data;
    logic                      buf_flush;
    logic                      fetch_word;

    // R15: size decode from the two straps
    function automatic mbx_pkg::mbx_size_t decode_size(input logic bm, input logic sz);
        mbx_pkg::mbx_size_t result;
        result = mbx_pkg::MBX_SIZE_LONG;
        if (bm && !sz) begin
            result = mbx_pkg::MBX_SIZE_WORD;
        end else if (bm && sz) begin
            result = mbx_pkg::MBX_SIZE_BYTE;
        end
        return result;
    endfunction : decode_size

    // pick part idx of a long word, in the configured order, onto the low lanes
    function automatic logic [35:0] select_part(
        input logic [35:0]         word,
        input mbx_pkg::mbx_size_t  size,
        input mbx_pkg::mbx_order_t order,
        input logic [1:0]          idx
    );
        logic [35:0] result;
        logic [1:0]  lane;
        result = word;
        lane   = idx;
        unique case (size)
            mbx_pkg::MBX_SIZE_LONG: begin
                result = word;
            end
            mbx_pkg::MBX_SIZE_WORD: begin
                if (order == mbx_pkg::MBX_ORDER_BIG) begin
                    lane = idx ^ 2'h1;
                end
                result = (lane[0]) ? (word >> mbx_pkg::WORD_HI_LSB) : word;
                result = result & mbx_pkg::MASK_WORD;
            end
            mbx_pkg::MBX_SIZE_BYTE: begin
                if (order == mbx_pkg::MBX_ORDER_BIG) begin
                    lane = ~idx;
                end
                result = word >> (lane * 36'(mbx_pkg::BYTE_SPAN));
                result = result & mbx_pkg::MASK_BYTE;
            end
            default: begin
                result = word;
            end
        endcase
        return result;
    endfunction : select_part

    // lanes that mailbox traffic may use for the current bus size
    always_comb begin
        size_mask = mbx_pkg::MASK_LONG;
        part_last = mbx_pkg::LONG_PARTS_LAST;
        unique case (bus_size_reg)
            mbx_pkg::MBX_SIZE_LONG: begin
                size_mask = mbx_pkg::MASK_LONG;
                part_last = mbx_pkg::LONG_PARTS_LAST;
            end
            mbx_pkg::MBX_SIZE_WORD: begin
                size_mask = mbx_pkg::MASK_WORD;
                part_last = mbx_pkg::WORD_PARTS_LAST;
            end
            mbx_pkg::MBX_SIZE_BYTE: begin
                size_mask = mbx_pkg::MASK_BYTE;
                part_last = mbx_pkg::BYTE_PARTS_LAST;
            end
            default: begin
                size_mask = mbx_pkg::MASK_LONG;
                part_last = mbx_pkg::LONG_PARTS_LAST;
            end
        endcase
    end

    // port a strobes: chip select low and enable high select the port
    assign a_sel        = !port_a_chip_select_n && port_a_enable && cfg_done_reg;
    assign a_mail_write = a_sel && port_a_write_read_n && port_a_mailbox_select;   // R2 R3
    assign a_mail_read  = a_sel && !port_a_write_read_n && port_a_mailbox_select;  // R2
    assign a_reading    = !port_a_chip_select_n && !port_a_write_read_n;

    // port b strobes; note the read direction is the high level here
    assign b_sel        = !port_b_chip_select_n && port_b_enable && cfg_done_reg;
    assign b_mail_write = b_sel && !port_b_write_n_read && port_b_mailbox_select;  // R2 R5
    assign b_mail_read  = b_sel && port_b_write_n_read && port_b_mailbox_select;   // R2
    assign b_fifo_read  = b_sel && port_b_write_n_read && !port_b_mailbox_select;  // R2
    assign b_reading    = !port_b_chip_select_n && port_b_write_n_read;

    // a word leaves the buffer only when nothing of the last one is still held
    assign fetch_word   = b_fifo_read && (part_idx_reg == 2'h0) && buf_valid;      // R24
    assign buf_ready    = fetch_word;
    assign buf_flush    = !master_reset_n;

    // whole 36-bit words from memory wait here; a stalled port b fills it
    mbx_buf2 #(
        .W (mbx_pkg::LONG_W)
    ) u_word_buf (
        .clk       (clk),
        .nrst      (nrst),
        .flush     (buf_flush),
        .in_valid  (mem_word_valid),
        .in_ready  (mem_word_ready),
        .in_data   (mem_word),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // configuration is caught on the rising edge of master reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            master_reset_n_reg <= 1'b0;
            cfg_done_reg       <= 1'b0;
            bus_size_reg       <= mbx_pkg::MBX_SIZE_LONG;
            order_reg          <= mbx_pkg::MBX_ORDER_BIG;
        end else begin
            master_reset_n_reg <= master_reset_n;
            if (!master_reset_n) begin
                cfg_done_reg <= 1'b0;
            end else if (!master_reset_n_reg) begin
                bus_size_reg <= decode_size(width_match_select, size_select);  // R15 R17
                order_reg    <= endian_order_select ? mbx_pkg::MBX_ORDER_BIG
                                                    : mbx_pkg::MBX_ORDER_LITTLE;  // R19
                cfg_done_reg <= 1'b1;                                          // R17
            end
        end
    end

    // ready flag rises one cycle after the caught configuration takes effect
    always_ff @(posedge clk) begin
        if (!nrst) begin
            full_or_input_ready_flag <= 1'b0;
        end else begin
            full_or_input_ready_flag <= cfg_done_reg && master_reset_n;  // R17
        end
    end

    // a-to-b mailbox: written from port a, emptied by a port b mail read
    always_ff @(posedge clk) begin
        if (!nrst || !master_reset_n) begin
            a_to_b_mailbox_reg     <= mbx_pkg::DATA_RST;
            a_to_b_mail_full_n_reg <= mbx_pkg::FLAG_IDLE;                   // R23
        end else if (a_mail_write && a_to_b_mail_full_n_reg) begin        // R8
            // write beats a same-cycle read so the new mail is never lost
            a_to_b_mailbox_reg     <= port_a_data_in & size_mask;         // R1 R4 R20
            a_to_b_mail_full_n_reg <= 1'b0;                                // R7
        end else if (b_mail_read) begin
            a_to_b_mail_full_n_reg <= 1'b1;                                // R10 R14
        end
    end

    // b-to-a mailbox: written from port b, emptied by a port a mail read
    always_ff @(posedge clk) begin
        if (!nrst || !master_reset_n) begin
            b_to_a_mailbox_reg     <= mbx_pkg::DATA_RST;
            b_to_a_mail_full_n_reg <= mbx_pkg::FLAG_IDLE;                   // R23
        end else if (b_mail_write && b_to_a_mail_full_n_reg) begin        // R8
            b_to_a_mailbox_reg     <= port_b_data_in & size_mask;         // R1 R6 R20
            b_to_a_mail_full_n_reg <= 1'b0;                                // R7
        end else if (a_mail_read) begin
            b_to_a_mail_full_n_reg <= 1'b1;                                // R12 R14
        end
    end

    // serialiser: first part goes out, the rest waits in the aux word
    always_ff @(posedge clk) begin
        if (!nrst || !master_reset_n) begin
            aux_word_reg <= mbx_pkg::DATA_RST;
            fifo_out_reg <= mbx_pkg::DATA_RST;
            part_idx_reg <= mbx_pkg::IDX_RST;
        end else if (fetch_word) begin
            aux_word_reg <= buf_data;                                         // R20
            fifo_out_reg <= select_part(buf_data, bus_size_reg, order_reg, 2'h0);  // R18 R21
            part_idx_reg <= (part_last == 2'h0) ? 2'h0 : 2'h1;                // R21 R24
        end else if (b_fifo_read && (part_idx_reg != 2'h0)) begin
            fifo_out_reg <= select_part(aux_word_reg, bus_size_reg, order_reg,
                                        part_idx_reg);                       // R18 R21
            part_idx_reg <= (part_idx_reg == part_last) ? 2'h0
                                                        : part_idx_reg + 2'h1;  // R24
        end
    end

    // tells port b a read would bring new fifo data out
    always_ff @(posedge clk) begin
        if (!nrst || !master_reset_n) begin
            port_b_fifo_data_ready <= 1'b0;
        end else begin
            port_b_fifo_data_ready <= (part_idx_reg != 2'h0) || buf_valid;
        end
    end

    // port a drive: only mail travels back, fifo select shows zeros
    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_a_data_out  <= mbx_pkg::DATA_RST;
            port_a_data_oe_n <= mbx_pkg::OE_OFF_N;
        end else begin
            port_a_data_oe_n <= !a_reading;                                   // R9
            port_a_data_out  <= port_a_mailbox_select ? (b_to_a_mailbox_reg & size_mask)
                                                      : mbx_pkg::DATA_RST;   // R9 R13
        end
    end

    // port b drive: mail needs no reordering, fifo data comes pre-arranged
    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_b_data_out  <= mbx_pkg::DATA_RST;
            port_b_data_oe_n <= mbx_pkg::OE_OFF_N;
        end else begin
            port_b_data_oe_n <= !b_reading;                                   // R9
            // unused lanes read as zero, a legal pick for undefined lines
            port_b_data_out  <= port_b_mailbox_select ? (a_to_b_mailbox_reg & size_mask)
                                                      : fifo_out_reg;        // R9 R11 R22
        end
    end

    // the mail flags leave straight from their flops
    assign a_to_b_mail_full_n = a_to_b_mail_full_n_reg;
    assign b_to_a_mail_full_n = b_to_a_mail_full_n_reg;

endmodule : mbx_top

// File: verif/mbx_checker.sv
`timescale 1ns/1ps

// mailbox flag and configuration timing seen at the top ports
module mbx_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_reset_n,
    input wire logic full_or_input_ready_flag,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_write_read_n,
    input wire logic port_a_enable,
    input wire logic port_a_mailbox_select,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_write_n_read,
    input wire logic port_b_enable,
    input wire logic port_b_mailbox_select,
    input wire logic a_to_b_mail_full_n,
    input wire logic b_to_a_mail_full_n
);
    // accesses only count once the ready flag is up; the block already accepts them from one cycle before it rises
    wire a_sel = full_or_input_ready_flag && master_reset_n && !port_a_chip_select_n
                 && port_a_enable && port_a_mailbox_select;
    wire b_sel = full_or_input_ready_flag && master_reset_n && !port_b_chip_select_n
                 && port_b_enable && port_b_mailbox_select;
    wire a_wr  = a_sel && port_a_write_read_n;
    wire a_rd  = a_sel && !port_a_write_read_n;
    wire b_wr  = b_sel && !port_b_write_n_read;
    wire b_rd  = b_sel && port_b_write_n_read;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence mrst_release;
        !master_reset_n ##1 master_reset_n;
    endsequence

    flags_after_mrst_a: assert property (!master_reset_n |=> a_to_b_mail_full_n && b_to_a_mail_full_n)
        else $error("mail flags not empty after master reset");
    a_write_fills_a: assert property (a_wr && a_to_b_mail_full_n |=> !a_to_b_mail_full_n)
        else $error("port a mail write did not fill");
    a_full_holds_a: assert property (!a_to_b_mail_full_n && !b_rd && master_reset_n |=> !a_to_b_mail_full_n)
        else $error("a to b flag left full without a read");
    b_read_empties_a: assert property (b_rd && !a_wr |=> a_to_b_mail_full_n)
        else $error("port b mail read did not empty");
    b_write_fills_a: assert property (b_wr && b_to_a_mail_full_n |=> !b_to_a_mail_full_n)
        else $error("port b mail write did not fill");
    b_full_holds_a: assert property (!b_to_a_mail_full_n && !a_rd && master_reset_n |=> !b_to_a_mail_full_n)
        else $error("b to a flag left full without a read");
    a_read_empties_a: assert property (a_rd && !b_wr |=> b_to_a_mail_full_n)
        else $error("port a mail read did not empty");
    cfg_ready_a: assert property (mrst_release |-> ##[1:4] full_or_input_ready_flag)
        else $error("ready flag late after master reset");
    mrst_drops_a: assert property (!master_reset_n |=> !full_or_input_ready_flag)
        else $error("ready flag high in master reset");
    ready_holds_a: assert property (full_or_input_ready_flag && master_reset_n |=> full_or_input_ready_flag)
        else $error("ready flag dropped");
endmodule : mbx_checker

bind mbx_top mbx_checker mbx_checker_inst (.clk, .nrst, .master_reset_n,
    .full_or_input_ready_flag, .port_a_chip_select_n, .port_a_write_read_n, .port_a_enable,
    .port_a_mailbox_select, .port_b_chip_select_n, .port_b_write_n_read, .port_b_enable,
    .port_b_mailbox_select, .a_to_b_mail_full_n, .b_to_a_mail_full_n);

// File: verif/mbx_mem_model.sv
`timescale 1ns/1ps

// fifo memory side: offers long words on valid/ready, optionally every other cycle
module mbx_mem_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        master_reset_n,
    input  wire logic        slow,
    output logic             mem_word_valid,
    input  wire logic        mem_word_ready,
    output logic [35:0]      mem_word
);
    logic [7:0] idx;
    logic       tick;

    // word k of the stream; the bench keeps its own copy of this pattern
    function automatic logic [35:0] word_of(input logic [7:0] k);
        return 36'h1_2345_6789 + 36'(k) * 36'h0_0101_0101;
    endfunction : word_of

    // offer held until taken; between offers the bus shows the inverse of the last word
    always_ff @(posedge clk) begin
        if (!nrst || !master_reset_n) begin
            idx            <= 8'h00;
            tick           <= 1'b0;
            mem_word_valid <= 1'b0;
            mem_word       <= 36'h0_0000_0000;
        end else if (!mem_word_valid || mem_word_ready) begin
            tick <= !tick;
            idx  <= idx + 8'(mem_word_valid);
            if (!slow || tick) begin
                mem_word_valid <= 1'b1;
                mem_word       <= word_of(idx + 8'(mem_word_valid));
            end else begin
                mem_word_valid <= 1'b0;
                mem_word       <= ~mem_word;
            end
        end
    end
endmodule : mbx_mem_model

// File: verif/testbench.sv
`timescale 1ns/1ps

// drives both ports and the straps; the memory side is the partner model
module testbench;
    logic        clk, nrst, master_reset_n, width_match_select, size_select, slow;
    logic        endian_order_select, full_or_input_ready_flag, port_b_fifo_data_ready;
    logic        port_a_chip_select_n, port_a_write_read_n, port_a_enable, port_a_mailbox_select;
    logic        port_b_chip_select_n, port_b_write_n_read, port_b_enable, port_b_mailbox_select;
    logic        port_a_data_oe_n, port_b_data_oe_n, mem_word_valid, mem_word_ready;
    logic        a_to_b_mail_full_n, b_to_a_mail_full_n;
    logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
    logic [35:0] mem_word, q, m, da, db;
    logic [2:0]  cfgs [5];
    int          fails, checks_done, n;

    mbx_top mbx_top_inst (.clk, .nrst, .master_reset_n, .width_match_select, .size_select,
        .endian_order_select, .full_or_input_ready_flag, .port_a_chip_select_n,
        .port_a_write_read_n, .port_a_enable, .port_a_mailbox_select, .port_a_data_in,
        .port_a_data_out, .port_a_data_oe_n, .port_b_chip_select_n, .port_b_write_n_read,
        .port_b_enable, .port_b_mailbox_select, .port_b_data_in, .port_b_data_out,
        .port_b_data_oe_n, .port_b_fifo_data_ready, .mem_word_valid, .mem_word_ready,
        .mem_word, .a_to_b_mail_full_n, .b_to_a_mail_full_n);

    mbx_mem_model mbx_mem_model_inst (.clk, .nrst, .master_reset_n, .slow, .mem_word_valid,
        .mem_word_ready, .mem_word);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // watchdog; the whole run needs only a few hundred cycles
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end

    function automatic logic [35:0] word_of(input int k);
        return 36'h1_2345_6789 + 36'(k) * 36'h0_0101_0101;
    endfunction : word_of

    // part i of word w in read order; j counts from the most significant end
    function automatic logic [35:0] part(input logic [35:0] w, input int n, input logic be,
                                         input int i);
        int j;
        j = be ? i : n - 1 - i;
        if (n == 1) return w;
        if (n == 2) return w >> (18 * (1 - j));
        return w >> (9 * (3 - j));
    endfunction : part

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input logic [35:0] msk);
        checks_done++;
        if ((got & msk) !== (exp & msk)) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one access on port b (pb) or a; result sampled once the output register has it
    task automatic acc(input logic pb, input logic wr, input logic mb, input logic [35:0] d,
                       output logic [35:0] r);
        @(posedge clk);
        port_a_chip_select_n  <= pb;
        port_b_chip_select_n  <= !pb;
        port_a_enable         <= 1'b1;
        port_b_enable         <= 1'b1;
        port_a_write_read_n   <= wr;
        port_b_write_n_read   <= !wr;
        port_a_mailbox_select <= mb;
        port_b_mailbox_select <= mb;
        port_a_data_in        <= d;
        port_b_data_in        <= d;
        @(posedge clk);
        port_a_chip_select_n  <= 1'b1;
        port_b_chip_select_n  <= 1'b1;
        port_a_enable         <= 1'b0;
        port_b_enable         <= 1'b0;
        port_a_data_in        <= ~d;
        port_b_data_in        <= ~d;
        repeat (2) @(posedge clk);
        #1 r = pb ? port_b_data_out : port_a_data_out;
    endtask : acc

    // straps {match, size, endian} caught as master reset is released
    task automatic cfg(input logic [2:0] c, input logic s);
        @(posedge clk);
        master_reset_n      <= 1'b0;
        width_match_select  <= c[2];
        size_select         <= c[1];
        endian_order_select <= c[0];
        slow                <= s;
        repeat (3) @(posedge clk);
        master_reset_n <= 1'b1;
        for (int t = 0; t < 20 && full_or_input_ready_flag !== 1'b1; t++) @(posedge clk);
        #1 chk({35'h0, full_or_input_ready_flag}, 36'h1, 36'h1);
        chk({34'h0, port_a_data_oe_n, port_b_data_oe_n}, 36'h3, 36'h3);
    endtask : cfg

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // each bus size and endian order in turn: mailboxes both ways, then fifo reads
    initial begin
        {nrst, master_reset_n, width_match_select, size_select, endian_order_select} = 5'h00;
        {port_a_chip_select_n, port_b_chip_select_n, slow} = 3'h6;
        {port_a_write_read_n, port_a_enable, port_a_mailbox_select} = 3'h0;
        {port_b_write_n_read, port_b_enable, port_b_mailbox_select} = 3'h0;
        port_a_data_in = 36'h0_0000_0000;
        port_b_data_in = 36'h0_0000_0000;
        cfgs = '{3'h1, 3'h5, 3'h4, 3'h7, 3'h6};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            cfg(cfgs[k], k[0]);
            m  = !cfgs[k][2] ? 36'hF_FFFF_FFFF : cfgs[k][1] ? 36'h0_0000_01FF : 36'h0_0003_FFFF;
            n  = !cfgs[k][2] ? 1 : cfgs[k][1] ? 4 : 2;
            da = 36'hA_5A5A_5A5A ^ 36'(k);
            db = 36'h6_9696_9696 ^ 36'(k);
            chk({34'h0, a_to_b_mail_full_n, b_to_a_mail_full_n}, 36'h3, 36'h3);
            acc(1'b0, 1'b1, 1'b1, da, q);
            chk({34'h0, a_to_b_mail_full_n, b_to_a_mail_full_n}, 36'h1, 36'h3);
            acc(1'b0, 1'b1, 1'b1, 36'h3_C3C3_C3C3, q);
            acc(1'b1, 1'b0, 1'b1, 36'h0_0000_0000, q);
            chk(q, da, m);
            chk({34'h0, a_to_b_mail_full_n, b_to_a_mail_full_n}, 36'h3, 36'h3);
            acc(1'b1, 1'b0, 1'b1, 36'h0_0000_0000, q);
            chk(q, da, m);
            acc(1'b1, 1'b1, 1'b1, db, q);
            chk({34'h0, a_to_b_mail_full_n, b_to_a_mail_full_n}, 36'h2, 36'h3);
            acc(1'b0, 1'b0, 1'b1, 36'h0_0000_0000, q);
            chk(q, db, m);
            chk({34'h0, a_to_b_mail_full_n, b_to_a_mail_full_n}, 36'h3, 36'h3);
            // nobody reads for a while, so the two-entry buffer must fill and refuse
            repeat (12) @(posedge clk);
            chk({35'h0, mem_word_ready}, 36'h0, 36'h1);
            for (int w = 0; w < 3; w++) begin
                for (int i = 0; i < n; i++) begin
                    for (int t = 0; t < 50 && port_b_fifo_data_ready !== 1'b1; t++) @(posedge clk);
                    acc(1'b1, 1'b0, 1'b0, 36'h0_0000_0000, q);
                    chk(q, part(word_of(w), n, cfgs[k][0], i), m);
                end
            end
        end
        report_and_stop();
    end
endmodule : testbench
